// >>> dgor_pkg.sv
// Package: register map, field layout, reset values and decoded types
// What this block does
// R1: Volume code zero mutes channel 1B fully
// R2: Codes 1..255 step half-decibel, 201 unity
// R3: Volume resets to unity code 201
// R4: Fine gain 0.1 dB steps, code 8 unity
// R5: Fine-gain low nibble reserved, reads zero
// R6: Output-2 source decode, codes 6-7 reserved
// R7: Independent codes swap DAC and bypass pins
// R8: Output-2 routing decode, codes 5,7 reserved
// R9: Routing ignored under independent source codes
// R10: Common mode: fraction of reference or half-supply
// R11: Low power valid for DAC, non-stereo routing
// R12: Positive pin drive decode, reset line-out
// R13: Level +24 to -12 dB, 6 dB steps
// R14: Software restricts extreme level codes by path
// R15: Negative bypass impedance 4.4k or 20k
// R16: Bypass input differential or single-ended
// R17: DAC channel 2 bandwidth 24 or 96 kHz
// R18: Registers hold written value, read it back
// R19: Software never writes reserved codes
package dgor_pkg;
    // Register addresses on the control port
    localparam logic [7:0] DGOR_ADDR_VOLUME = 8'h69;
    localparam logic [7:0] DGOR_ADDR_FINE = 8'h6A;
    localparam logic [7:0] DGOR_ADDR_SRC_ROUTE = 8'h6B;
    localparam logic [7:0] DGOR_ADDR_DRIVE_LEVEL = 8'h6C;
    // Reset values
    localparam logic [7:0] DGOR_RST_VOLUME = 8'hC9;
    localparam logic [7:0] DGOR_RST_FINE = 8'h80;
    localparam logic [7:0] DGOR_RST_SRC_ROUTE = 8'h20;
    localparam logic [7:0] DGOR_RST_DRIVE_LEVEL = 8'h20;
    // Field positions
    localparam int DGOR_FINE_LSB = 4;
    localparam int DGOR_SRC_LSB = 5;
    localparam int DGOR_ROUTE_LSB = 2;
    localparam int DGOR_MID_RAIL_REFERENCE_BIT = 1;
    localparam int DGOR_LP_BIT = 0;
    localparam int DGOR_DRIVE_LSB = 6;
    localparam int DGOR_LEVEL_LSB = 3;
    localparam int DGOR_IMP_BIT = 2;
    localparam int DGOR_BYPSE_BIT = 1;
    localparam int DGOR_BW_BIT = 0;
    // Volume and gain codes
    localparam logic [7:0] DGOR_VOL_MUTE = 8'h00;
    localparam logic [7:0] DGOR_VOL_UNITY = 8'hC9;
    localparam logic [3:0] DGOR_FINE_UNITY = 4'h8;
    localparam logic [3:0] DGOR_FINE_RSVD_MASK = 4'h0;

    typedef enum logic [2:0] {
        DGOR_SRC_OFF, DGOR_SRC_DAC, DGOR_SRC_BYPASS, DGOR_SRC_SUM,
        DGOR_SRC_IND_DP, DGOR_SRC_IND_DM, DGOR_SRC_RSVD6, DGOR_SRC_RSVD7
    } dgor_src_t;

    typedef enum logic [2:0] {
        DGOR_RT_DIFF, DGOR_RT_STEREO_SE, DGOR_RT_MONO_P, DGOR_RT_MONO_M,
        DGOR_RT_PDIFF_MCM, DGOR_RT_RSVD5, DGOR_RT_PDIFF_PCM, DGOR_RT_RSVD7
    } dgor_route_t;

    typedef enum logic [1:0] {
        DGOR_DRV_LINE, DGOR_DRV_HP, DGOR_DRV_4OHM, DGOR_DRV_RCV
    } dgor_drive_t;

    // Control port access
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dgor_req_t;

    // Decoded settings towards the analog and digital paths
    typedef struct packed {
        logic chan1b_mute;
        logic signed [9:0] chan1b_vol_half_db;
        logic signed [4:0] chan1b_fine_tenth_db;
        logic out2_enable;
        logic out2_pos_from_dac;
        logic out2_pos_from_bypass;
        logic out2_neg_from_dac;
        logic out2_neg_from_bypass;
        logic out2_independent;
        logic out2_pos_is_cm;
        logic out2_neg_is_cm;
        logic out2_cfg_reserved;
        logic out2_cm_half_supply;
        logic out2_low_power;
        dgor_drive_t out2_pos_drive;
        logic signed [5:0] out2_pos_level_db;
        logic in2_neg_bypass_20k;
        logic in2_bypass_single_ended;
        logic dac2_wide_band;
    } dgor_cfg_t;
endpackage : dgor_pkg

// >>> dgor_regs.sv
// Register bank for channel 1B gain and output-2 routing
`timescale 1ns/1ns
`default_nettype none
module dgor_regs
    import dgor_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control port
    input wire dgor_req_t req,
    input wire logic req_valid,
    output logic [7:0] rdata,
    output logic addr_hit,
    // Decoded settings
    output dgor_cfg_t cfg
);
    logic [7:0] volume_ff, nxt_volume;
    logic [3:0] fine_ff, nxt_fine;
    logic [7:0] src_route_ff, nxt_src_route;
    logic [7:0] drive_level_ff, nxt_drive_level;
    logic [7:0] rdata_ff, nxt_rdata;

    wire logic hit_vol = req.addr == DGOR_ADDR_VOLUME;
    wire logic hit_fine = req.addr == DGOR_ADDR_FINE;
    wire logic hit_sr = req.addr == DGOR_ADDR_SRC_ROUTE;
    wire logic hit_dl = req.addr == DGOR_ADDR_DRIVE_LEVEL;
    wire logic wr_en = req_valid && req.wr;

    // Writes update only the addressed register
    assign nxt_volume = (wr_en && hit_vol) ? req.wdata : volume_ff; // R18
    // Reserved low nibble is never stored
    assign nxt_fine = (wr_en && hit_fine) ? req.wdata[7:4] : fine_ff; // R5
    assign nxt_src_route = (wr_en && hit_sr) ? req.wdata : src_route_ff; // R18
    assign nxt_drive_level = (wr_en && hit_dl) ? req.wdata : drive_level_ff; // R18

    // Read mux; unmapped addresses return zero
    assign nxt_rdata = hit_vol ? volume_ff :
        hit_fine ? {fine_ff, DGOR_FINE_RSVD_MASK} : // R5
        hit_sr ? src_route_ff :
        hit_dl ? drive_level_ff : 8'h00; // R18
    assign addr_hit = hit_vol | hit_fine | hit_sr | hit_dl;
    assign rdata = rdata_ff;

    always_ff @(posedge clk) begin
        if (reset) begin
            volume_ff <= DGOR_RST_VOLUME; // R3
            fine_ff <= DGOR_RST_FINE[7:4]; // R4
            src_route_ff <= DGOR_RST_SRC_ROUTE; // R6
            drive_level_ff <= DGOR_RST_DRIVE_LEVEL; // R12 R13
            rdata_ff <= 8'h00;
        end else begin
            volume_ff <= nxt_volume;
            fine_ff <= nxt_fine;
            src_route_ff <= nxt_src_route;
            drive_level_ff <= nxt_drive_level;
            rdata_ff <= (req_valid && !req.wr) ? nxt_rdata : rdata_ff;
        end
    end

    // Field extraction
    wire dgor_src_t src = dgor_src_t'(src_route_ff[DGOR_SRC_LSB +: 3]);
    wire dgor_route_t route = dgor_route_t'(src_route_ff[DGOR_ROUTE_LSB +: 3]);
    wire logic [2:0] level = drive_level_ff[DGOR_LEVEL_LSB +: 3];

    // Code 201 is 0 dB, step is half a decibel
    wire logic signed [9:0] vol_half_db =
        $signed({2'b00, volume_ff}) - $signed({2'b00, DGOR_VOL_UNITY}); // R2
    // Code 8 is 0 dB, step is a tenth of a decibel
    wire logic signed [4:0] fine_tenth =
        $signed({1'b0, fine_ff}) - $signed({1'b0, DGOR_FINE_UNITY}); // R4
    // Code 4 is 0 dB; code 7 reserved, held at unity to stay safe
    wire logic signed [5:0] level_db = (level == 3'd7) ? 6'sd0 :
        6'sd24 - $signed({3'b000, level}) * 6'sd6; // R13

    wire logic is_dac = src == DGOR_SRC_DAC || src == DGOR_SRC_SUM;
    wire logic is_byp = src == DGOR_SRC_BYPASS || src == DGOR_SRC_SUM;
    wire logic indep = src == DGOR_SRC_IND_DP || src == DGOR_SRC_IND_DM; // R7
    wire logic en = src != DGOR_SRC_OFF && src != DGOR_SRC_RSVD6
        && src != DGOR_SRC_RSVD7; // R6
    // Routing field ignored while sources are independent
    wire logic rt_ok = !indep && en; // R9
    wire logic p_cm = rt_ok && route == DGOR_RT_PDIFF_PCM; // R8
    wire logic m_cm = rt_ok && route == DGOR_RT_PDIFF_MCM; // R8
    wire logic p_used = rt_ok && route != DGOR_RT_MONO_M && !p_cm; // R8
    wire logic m_used = rt_ok && route != DGOR_RT_MONO_P && !m_cm; // R8
    wire logic rt_rsvd = route == DGOR_RT_RSVD5 || route == DGOR_RT_RSVD7; // R8

    always_comb begin
        cfg.chan1b_mute = volume_ff == DGOR_VOL_MUTE; // R1
        cfg.chan1b_vol_half_db = vol_half_db; // R2
        cfg.chan1b_fine_tenth_db = fine_tenth; // R4
        cfg.out2_enable = en; // R6
        cfg.out2_independent = indep;
        cfg.out2_pos_from_dac = (p_used && is_dac) || src == DGOR_SRC_IND_DP; // R7
        cfg.out2_pos_from_bypass = (p_used && is_byp) || src == DGOR_SRC_IND_DM; // R7
        cfg.out2_neg_from_dac = (m_used && is_dac) || src == DGOR_SRC_IND_DM; // R7
        cfg.out2_neg_from_bypass = (m_used && is_byp) || src == DGOR_SRC_IND_DP; // R7
        cfg.out2_pos_is_cm = p_cm;
        cfg.out2_neg_is_cm = m_cm;
        cfg.out2_cfg_reserved = rt_ok && rt_rsvd;
        cfg.out2_cm_half_supply = src_route_ff[DGOR_MID_RAIL_REFERENCE_BIT]; // R10
        // Low power only honoured where it is valid
        cfg.out2_low_power = src_route_ff[DGOR_LP_BIT] && src == DGOR_SRC_DAC
            && route != DGOR_RT_STEREO_SE; // R11
        cfg.out2_pos_drive = dgor_drive_t'(drive_level_ff[DGOR_DRIVE_LSB +: 2]); // R12
        cfg.out2_pos_level_db = level_db; // R13
        cfg.in2_neg_bypass_20k = drive_level_ff[DGOR_IMP_BIT]; // R15
        cfg.in2_bypass_single_ended = drive_level_ff[DGOR_BYPSE_BIT]; // R16
        cfg.dac2_wide_band = drive_level_ff[DGOR_BW_BIT]; // R17
    end
endmodule : dgor_regs
`default_nettype wire

// >>> dgor_regs_asserts.sv
// Port assertions for the channel 1B gain and output-2 register bank
`timescale 1ns/1ns
`default_nettype none
module dgor_regs_asserts
    import dgor_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control port
    input wire dgor_req_t req,
    input wire logic req_valid,
    input wire logic [7:0] rdata,
    input wire logic addr_hit,
    // Decoded settings
    input wire dgor_cfg_t cfg
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic wv = req_valid && req.wr;
    wire logic w_vol = wv && req.addr == DGOR_ADDR_VOLUME;
    wire logic w_src = wv && req.addr == DGOR_ADDR_SRC_ROUTE;
    wire logic w_lvl = wv && req.addr == DGOR_ADDR_DRIVE_LEVEL;
    wire logic [7:0] d = req.wdata;
    vol_mute_a: assert property (w_vol |=> cfg.chan1b_mute == ($past(d) == 8'h00))
        else $error("mute flag wrong");
    vol_step_a: assert property (w_vol |=>
        int'(cfg.chan1b_vol_half_db) == int'($past(d)) - 201) else $error("volume step wrong");
    fine_gain_a: assert property (wv && req.addr == DGOR_ADDR_FINE |=>
        int'(cfg.chan1b_fine_tenth_db) == int'($past(d[7:4])) - 8) else $error("fine gain wrong");
    src_off_a: assert property (w_src |=>
        cfg.out2_enable == !($past(d[7:5]) inside {3'h0, 3'h6, 3'h7}))
        else $error("source enable wrong");
    route_cm_a: assert property (w_src && d[7:5] == 3'h1 |=>
        {cfg.out2_pos_is_cm, cfg.out2_neg_is_cm} == {$past(d[4:2]) == 3'h6, $past(d[4:2]) == 3'h4})
        else $error("common mode pin wrong");
    fine_read_a: assert property (req_valid && !req.wr && req.addr == DGOR_ADDR_FINE |=>
        rdata[3:0] == 4'h0) else $error("reserved bits not zero");
    rdata_hold_a: assert property (!(req_valid && !req.wr) |=> $stable(rdata))
        else $error("read data changed without read");
    indep_route_a: assert property (w_src && d[7:5] == 3'h4 |=>
        cfg.out2_pos_from_dac && cfg.out2_neg_from_bypass) else $error("independent route wrong");
    cm_low_power_a: assert property (w_src |=> cfg.out2_cm_half_supply == $past(d[1]) &&
        cfg.out2_low_power == ($past(d) ==? 8'b001?_??_?1 && $past(d[4:2]) != 3'h1))
        else $error("common mode or low power wrong");
    pos_level_a: assert property (w_lvl && d[5:3] != 3'h7 |=>
        int'(cfg.out2_pos_level_db) == 24 - 6 * int'($past(d[5:3]))) else $error("level wrong");
    drive_bits_a: assert property (w_lvl |=>
        cfg.out2_pos_drive == $past(d[7:6]) && cfg.in2_neg_bypass_20k == $past(d[2]) &&
        cfg.in2_bypass_single_ended == $past(d[1]) && cfg.dac2_wide_band == $past(d[0]))
        else $error("drive or input bits wrong");
endmodule : dgor_regs_asserts
`default_nettype wire

// >>> dgor_regs_tb_top.sv
// Self-checking bench for the channel 1B gain and output-2 register bank
`timescale 1ns/1ns
`default_nettype none
module dgor_regs_tb_top
    import dgor_pkg::*;
;
    logic clk = 0, reset = 1, req_valid = 0;
    dgor_req_t req = '0;
    logic [7:0] rdata;
    logic addr_hit;
    dgor_cfg_t cfg;
    int miscompares = 0, checks_done = 0;
    logic [7:0] rst [4] = '{DGOR_RST_VOLUME, DGOR_RST_FINE, DGOR_RST_SRC_ROUTE,
        DGOR_RST_DRIVE_LEVEL};
    logic [7:0] vols [4] = '{8'h00, 8'h01, 8'hC9, 8'hFF};
    always #5 clk = ~clk;
    dgor_regs dgor_regs_inst (.clk(clk), .reset(reset), .req(req), .req_valid(req_valid),
        .rdata(rdata), .addr_hit(addr_hit), .cfg(cfg));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Strobe for one edge, then idle one cycle so valid never toggles twice in a step
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] dat);
        req <= '{w, a, dat};
        req_valid <= 1'b1;
        @(negedge clk);
        req_valid <= 1'b0;
        @(negedge clk);
    endtask : acc
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        give_verdict;
    end
    initial begin
        repeat (5) @(negedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, DGOR_ADDR_VOLUME + 8'(i), 8'h00);
            chk(rdata, rst[i]);
            chk(addr_hit, 1'b1);
        end
        $display("reset test done");
        foreach (vols[i]) begin
            acc(1'b1, DGOR_ADDR_VOLUME, vols[i]);
            acc(1'b0, DGOR_ADDR_VOLUME, 8'h00);
            chk(rdata, vols[i]);
            chk(cfg.chan1b_mute, vols[i] == 0);
            chk(cfg.chan1b_vol_half_db, 16'(int'(vols[i]) - 201));
        end
        acc(1'b1, DGOR_ADDR_FINE, 8'hFF);
        acc(1'b0, DGOR_ADDR_FINE, 8'h00);
        chk(rdata, 8'hF0);
        chk(cfg.chan1b_fine_tenth_db, 16'h0007);
        $display("gain test done");
        for (int s = 0; s < 6; s++) begin
            acc(1'b1, DGOR_ADDR_SRC_ROUTE, {s[2:0], 5'h00});
            chk(cfg.out2_enable, s != 0);
            chk(cfg.out2_independent, s > 3);
            if (s > 3) chk({cfg.out2_pos_from_dac, cfg.out2_neg_from_bypass}, {2{s == 4}});
            if (s > 3) chk({cfg.out2_pos_from_bypass, cfg.out2_neg_from_dac}, {2{s == 5}});
        end
        for (int r = 0; r < 7; r++) begin
            if (r == 5) continue;
            acc(1'b1, DGOR_ADDR_SRC_ROUTE, {3'h1, r[2:0], 2'h3});
            chk(cfg.out2_low_power, r != 1);
            chk(cfg.out2_cm_half_supply, 1'b1);
            chk({cfg.out2_pos_is_cm, cfg.out2_neg_is_cm}, {r == 6, r == 4});
            chk(cfg.out2_cfg_reserved, 1'b0);
        end
        acc(1'b1, DGOR_ADDR_SRC_ROUTE, 8'h63);
        chk(cfg.out2_low_power, 1'b0);
        $display("output source test done");
        // Single-ended DAC path so the extreme level codes stay legal
        acc(1'b1, DGOR_ADDR_SRC_ROUTE, 8'h24);
        for (int l = 0; l < 7; l++) begin
            // Lowest level only with the low bypass impedance
            acc(1'b1, DGOR_ADDR_DRIVE_LEVEL, {l[1:0], l[2:0], (l == 6) ? 3'h2 : l[2:0]});
            chk(cfg.out2_pos_level_db, 16'(24 - 6 * l));
            chk(cfg.out2_pos_drive, l[1:0]);
            chk(cfg.in2_neg_bypass_20k, (l == 6) ? 1'b0 : l[2]);
            chk({cfg.in2_bypass_single_ended, cfg.dac2_wide_band}, l[1:0]);
        end
        $display("level test done");
        acc(1'b1, 8'h70, 8'hAA);
        chk(addr_hit, 1'b0);
        acc(1'b0, 8'h70, 8'h00);
        chk(rdata, 8'h00);
        acc(1'b0, DGOR_ADDR_DRIVE_LEVEL, 8'h00);
        chk(rdata, 8'hB2);
        $display("unmapped test done");
        reset <= 1'b1;
        repeat (2) @(negedge clk);
        reset <= 1'b0;
        acc(1'b0, DGOR_ADDR_VOLUME, 8'h00);
        chk(rdata, DGOR_VOL_UNITY);
        $display("second reset test done");
        give_verdict;
    end
endmodule : dgor_regs_tb_top
bind dgor_regs dgor_regs_asserts dgor_regs_asserts_inst (.clk(clk), .reset(reset), .req(req),
    .req_valid(req_valid), .rdata(rdata), .addr_hit(addr_hit), .cfg(cfg));
`default_nettype wire
